// ===== ivd_dispatch.sv
`timescale 1ns/100ps
// Overview of operation
// - Fast interrupt enters its routine within 5 cycles, returns in 3 cycles.
// - Fast entry saves flags and PC, then branches to the fast vector register.
// - Fast return instruction reloads flags and PC from the saved registers.
// - Exit priority bit 3 makes the level-7 source take the fast path.
// - Fast routine may switch to register bank 1 instead of stacking.
// - Fixed vector table spans FFFFDC to FFFFFF, four bytes per entry.
// - Fixed entries: undefined, overflow, break, match, watchdog, pin, reset.
// - Break uses variable entry when byte FFFFE7 reads FF.
// - Debugger break and single step use emulator vector, ignore mask.
// - Variable table is 256 bytes starting at the table base.
// - Variable entry is base plus four times number; zero is unmaskable break.
// - DMA 8-11, timer A 12-16, serial 17-20, timer B0 21.
// - Every accepted request except a fast-path one branches to the address read from its entry.
// - Maskable accepted only with mask flag, request bit, level above processor level.
// - Request bit clears in hardware when the request is acknowledged.
module ivd_dispatch (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [ivd_pkg::NUM_SRC-1:0] req_set_in,
    input wire logic [ivd_pkg::NUM_SRC-1:0] req_clear_in,
    input wire logic [ivd_pkg::NUM_SRC*ivd_pkg::PRI_W-1:0] src_level_in,
    input wire logic i_flag_in,
    input wire logic [ivd_pkg::PRI_W-1:0] processor_priority_level_in,
    input wire logic [ivd_pkg::EXIT_W-1:0] exit_priority_in,
    input wire logic fast_bank_mode_in,
    input wire logic [ivd_pkg::FLAG_W-1:0] flag_register_in,
    input wire logic [ivd_pkg::ADDR_W-1:0] pc_in,
    input wire logic [ivd_pkg::ADDR_W-1:0] fast_vector_reg_in,
    input wire logic [ivd_pkg::ADDR_W-1:0] vector_table_base_in,
    input wire logic [ivd_pkg::NUM_SP-1:0] sp_event_in,
    input wire logic [ivd_pkg::SWNUM_W-1:0] int_number_in,
    input wire logic fast_return_instr_in,
    input wire logic [7:0] mem_data_in,
    input wire logic mem_ack_in,
    output logic mem_req_out,
    output logic [ivd_pkg::ADDR_W-1:0] mem_addr_out,
    output logic branch_valid_out,
    output logic [ivd_pkg::ADDR_W-1:0] branch_addr_out,
    output logic [ivd_pkg::NUM_SRC-1:0] req_pending_out,
    output logic [ivd_pkg::NUM_SRC-1:0] ack_out,
    output logic [ivd_pkg::FLAG_W-1:0] saved_flag_reg_out,
    output logic [ivd_pkg::ADDR_W-1:0] saved_pc_reg_out,
    output logic restore_valid_out,
    output logic [ivd_pkg::FLAG_W-1:0] restore_flag_out,
    output logic [ivd_pkg::ADDR_W-1:0] restore_pc_out,
    output logic bank1_select_out,
    output logic in_fast_out,
    output logic busy_out
);
    import ivd_pkg::*;

    ivd_state_e state_d, state_q;
    logic [NUM_SRC-1:0] req_d, req_q, ack_d, ack_q;
    logic [NUM_SP-1:0] sp_d, sp_q;
    logic [SWNUM_W-1:0] num_d, num_q;
    logic [CNT_W-1:0] cnt_d, cnt_q;
    logic start_d, start_q;
    logic [ADDR_W-1:0] faddr_d, faddr_q;
    logic [2:0] fbytes_d, fbytes_q;
    logic bv_d, bv_q, rv_d, rv_q, fast_d, fast_q, bank_d, bank_q;
    logic busy_d, busy_q;
    logic [ADDR_W-1:0] baddr_d, baddr_q, spc_d, spc_q;
    logic [FLAG_W-1:0] sflg_d, sflg_q;
    logic fetch_done;
    logic [31:0] fetch_data;
    logic mask_win;
    logic [4:0] mask_idx;
    logic [PRI_W-1:0] best_lvl;
    logic sp_win;
    logic [3:0] sp_idx;

    function automatic logic [ADDR_W-1:0] var_entry(input logic [ADDR_W-1:0] base,
                                                    input logic [SWNUM_W-1:0] num);
        var_entry = base + {16'h0000, num, 2'b00};
    endfunction

    function automatic logic [ADDR_W-1:0] fixed_entry(input logic [3:0] idx);
        case (idx)
            4'h0: fixed_entry = VEC_RESET;
            4'h3: fixed_entry = VEC_NMI;
            4'h4: fixed_entry = VEC_WDT;
            4'h5: fixed_entry = VEC_AMATCH;
            4'h6: fixed_entry = VEC_UNDEF;
            4'h7: fixed_entry = VEC_OVF;
            default: fixed_entry = VEC_EMU;
        endcase
    endfunction

    // ============================================================
    // Arbitration
    always_comb begin
        sp_win = 1'b0;
        sp_idx = 4'h0;
        for (int i = NUM_SP - 1; i >= 0; i--) begin
            if (sp_q[i]) begin
                sp_win = 1'b1;
                sp_idx = 4'(i);
            end
        end
        mask_win = 1'b0;
        mask_idx = 5'h00;
        best_lvl = processor_priority_level_in;
        for (int i = FIRST_PERIPH; i < NUM_SRC; i++) begin
            if (req_q[i] && src_level_in[i*PRI_W +: PRI_W] > best_lvl) begin
                mask_win = i_flag_in;
                mask_idx = 5'(i);
                best_lvl = src_level_in[i*PRI_W +: PRI_W];
            end
        end
    end

    // ============================================================
    // Dispatch sequencer
    always_comb begin
        state_d = state_q;
        req_d = (req_q & ~req_clear_in) | req_set_in;
        sp_d = sp_q | sp_event_in;
        num_d = num_q;
        cnt_d = cnt_q;
        start_d = 1'b0;
        faddr_d = faddr_q;
        fbytes_d = fbytes_q;
        ack_d = '0;
        bv_d = 1'b0;
        rv_d = 1'b0;
        baddr_d = baddr_q;
        fast_d = fast_q;
        bank_d = bank_q;
        sflg_d = sflg_q;
        spc_d = spc_q;
        if (sp_event_in[SP_INT]) begin
            num_d = int_number_in;
        end
        unique case (state_q)
            ST_IDLE: begin
                if (fast_q && fast_return_instr_in) begin
                    state_d = ST_FAST_OUT;
                    cnt_d = 3'h1;
                end else if (sp_win) begin
                    sp_d[sp_idx] = sp_event_in[sp_idx];
                    start_d = 1'b1;
                    fbytes_d = VEC_BYTES;
                    state_d = ST_FETCH;
                    if (sp_idx == 4'(SP_BREAK)) begin
                        faddr_d = VEC_BREAK_CHK;
                        fbytes_d = BREAK_CHK_BYTES;
                        state_d = ST_BREAK_CHK;
                    end else if (sp_idx == 4'(SP_INT)) begin
                        faddr_d = var_entry(vector_table_base_in, num_q);
                    end else if (sp_idx == 4'(SP_DBG_BREAK) || sp_idx == 4'(SP_STEP)) begin
                        faddr_d = VEC_EMU;
                        fbytes_d = EMU_BYTES;
                    end else begin
                        faddr_d = fixed_entry(sp_idx);
                    end
                end else if (mask_win) begin
                    req_d[mask_idx] = req_set_in[mask_idx];
                    ack_d[mask_idx] = 1'b1;
                    if (exit_priority_in[HS_BIT] && best_lvl == HS_LEVEL && !fast_q) begin
                        state_d = ST_FAST_IN;
                        cnt_d = 3'h1;
                        sflg_d = flag_register_in;
                        spc_d = pc_in;
                        fast_d = 1'b1;
                        bank_d = fast_bank_mode_in;
                    end else begin
                        faddr_d = var_entry(vector_table_base_in, 6'(mask_idx));
                        fbytes_d = VEC_BYTES;
                        start_d = 1'b1;
                        state_d = ST_FETCH;
                    end
                end
            end
            ST_FAST_IN: begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == FAST_ENTRY_CYC - 3'h1) begin
                    bv_d = 1'b1;
                    baddr_d = fast_vector_reg_in;
                    state_d = ST_DONE;
                end
            end
            ST_FAST_OUT: begin
                cnt_d = cnt_q + 3'h1;
                if (cnt_q == FAST_RET_CYC - 3'h1) begin
                    rv_d = 1'b1;
                    fast_d = 1'b0;
                    bank_d = 1'b0;
                    state_d = ST_DONE;
                end
            end
            ST_BREAK_CHK: begin
                if (fetch_done) begin
                    faddr_d = (fetch_data[7:0] == BREAK_REDIRECT) ?
                              var_entry(vector_table_base_in, 6'h00) : VEC_BREAK;
                    fbytes_d = VEC_BYTES;
                    start_d = 1'b1;
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (fetch_done) begin
                    bv_d = 1'b1;
                    baddr_d = fetch_data[ADDR_W-1:0];
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                // One idle cycle lets the core take the branch before re-arbitration
                state_d = ST_IDLE;
            end
        endcase
        // Registered so that the busy output comes straight from a flop
        busy_d = (state_d != ST_IDLE);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q <= ST_IDLE;
            req_q <= '0;
            sp_q <= 10'h001;
            num_q <= '0;
            cnt_q <= 3'h0;
            start_q <= 1'b0;
            faddr_q <= '0;
            fbytes_q <= 3'h0;
            ack_q <= '0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            baddr_q <= '0;
            fast_q <= 1'b0;
            bank_q <= 1'b0;
            sflg_q <= '0;
            spc_q <= '0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            req_q <= req_d;
            sp_q <= sp_d;
            num_q <= num_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            faddr_q <= faddr_d;
            fbytes_q <= fbytes_d;
            ack_q <= ack_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            baddr_q <= baddr_d;
            fast_q <= fast_d;
            bank_q <= bank_d;
            sflg_q <= sflg_d;
            spc_q <= spc_d;
            busy_q <= busy_d;
        end
    end

    ivd_vec_fetch u_fetch (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .start_in(start_q),
        .addr_in(faddr_q),
        .nbytes_in(fbytes_q),
        .mem_data_in(mem_data_in),
        .mem_ack_in(mem_ack_in),
        .mem_req_out(mem_req_out),
        .mem_addr_out(mem_addr_out),
        .data_out(fetch_data),
        .done_out(fetch_done)
    );

    assign branch_valid_out = bv_q;
    assign branch_addr_out = baddr_q;
    assign req_pending_out = req_q;
    assign ack_out = ack_q;
    assign saved_flag_reg_out = sflg_q;
    assign saved_pc_reg_out = spc_q;
    assign restore_valid_out = rv_q;
    assign restore_flag_out = sflg_q;
    assign restore_pc_out = spc_q;
    assign bank1_select_out = bank_q;
    assign in_fast_out = fast_q;
    assign busy_out = busy_q;
endmodule

// ===== ivd_pkg.sv
package ivd_pkg;
    // ============================================================
    // Widths
    localparam int ADDR_W = 24;
    localparam int FLAG_W = 16;
    localparam int PRI_W = 3;
    localparam int NUM_SRC = 22;
    localparam int FIRST_PERIPH = 8;
    localparam int SWNUM_W = 6;
    localparam int CNT_W = 3;
    localparam int EXIT_W = 8;
    // ============================================================
    // Fixed vector table entries
    localparam logic [23:0] VEC_UNDEF = 24'hFFFFDC;
    localparam logic [23:0] VEC_OVF = 24'hFFFFE0;
    localparam logic [23:0] VEC_BREAK = 24'hFFFFE4;
    localparam logic [23:0] VEC_BREAK_CHK = 24'hFFFFE7;
    localparam logic [23:0] VEC_AMATCH = 24'hFFFFE8;
    localparam logic [23:0] VEC_WDT = 24'hFFFFF0;
    localparam logic [23:0] VEC_NMI = 24'hFFFFF8;
    localparam logic [23:0] VEC_RESET = 24'hFFFFFC;
    localparam logic [23:0] VEC_EMU = 24'h000020;
    localparam logic [7:0] BREAK_REDIRECT = 8'hFF;
    localparam logic [23:0] VAR_TABLE_BYTES = 24'h000100;
    // ============================================================
    // Entry sizes, levels, bits
    localparam logic [2:0] VEC_BYTES = 3'h4;
    localparam logic [2:0] EMU_BYTES = 3'h3;
    localparam logic [2:0] BREAK_CHK_BYTES = 3'h1;
    localparam logic [PRI_W-1:0] HS_LEVEL = 3'h7;
    localparam int HS_BIT = 3;
    // ============================================================
    // Timing in cycles
    localparam logic [CNT_W-1:0] FAST_ENTRY_CYC = 3'h5;
    localparam logic [CNT_W-1:0] FAST_RET_CYC = 3'h3;
    // ============================================================
    // Special source indices, highest priority first
    localparam int SP_RESET = 0;
    localparam int SP_DBG_BREAK = 1;
    localparam int SP_STEP = 2;
    localparam int SP_NMI = 3;
    localparam int SP_WDT = 4;
    localparam int SP_AMATCH = 5;
    localparam int SP_UNDEF = 6;
    localparam int SP_OVF = 7;
    localparam int SP_BREAK = 8;
    localparam int SP_INT = 9;
    localparam int NUM_SP = 10;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_FAST_IN = 6'h02,
        ST_FAST_OUT = 6'h04,
        ST_BREAK_CHK = 6'h08,
        ST_FETCH = 6'h10,
        ST_DONE = 6'h20
    } ivd_state_e;
endpackage

// ===== ivd_vec_fetch.sv
`timescale 1ns/100ps
module ivd_vec_fetch (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic start_in,
    input wire logic [ivd_pkg::ADDR_W-1:0] addr_in,
    input wire logic [2:0] nbytes_in,
    input wire logic [7:0] mem_data_in,
    input wire logic mem_ack_in,
    output logic mem_req_out,
    output logic [ivd_pkg::ADDR_W-1:0] mem_addr_out,
    output logic [31:0] data_out,
    output logic done_out
);
    import ivd_pkg::*;

    logic req_d, req_q, done_d, done_q;
    logic [ADDR_W-1:0] addr_d, addr_q;
    logic [31:0] data_d, data_q;
    logic [2:0] cnt_d, cnt_q, last_d, last_q;

    // ============================================================
    // Byte walk, lowest address first
    always_comb begin
        req_d = req_q;
        addr_d = addr_q;
        data_d = data_q;
        cnt_d = cnt_q;
        last_d = last_q;
        done_d = 1'b0;
        if (start_in && !req_q) begin
            req_d = 1'b1;
            addr_d = addr_in;
            data_d = 32'h00000000;
            cnt_d = 3'h0;
            last_d = nbytes_in - 3'h1;
        end else if (req_q && mem_ack_in) begin
            data_d[cnt_q[1:0]*8 +: 8] = mem_data_in;
            addr_d = addr_q + 24'h000001;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == last_q) begin
                req_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            req_q <= 1'b0;
            addr_q <= '0;
            data_q <= 32'h00000000;
            cnt_q <= 3'h0;
            last_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            req_q <= req_d;
            addr_q <= addr_d;
            data_q <= data_d;
            cnt_q <= cnt_d;
            last_q <= last_d;
            done_q <= done_d;
        end
    end

    assign mem_req_out = req_q;
    assign mem_addr_out = addr_q;
    assign data_out = data_q;
    assign done_out = done_q;
endmodule

// ===== ivd_mem_model.sv
`timescale 1ns/100ps
module ivd_mem_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic mem_req_in,
    input wire logic [23:0] mem_addr_in,
    input wire logic slow_in,
    input wire logic break_ff_in,
    output logic [7:0] mem_data_out,
    output logic mem_ack_out
);
    // ============================================================
    // Byte store: each byte is derived from its own address, except FFFFE7 reads FF while break_ff_in is set
    logic skip_q;
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_ack_out <= 1'b0;
            mem_data_out <= 8'h00;
            skip_q <= 1'b0;
        end else begin
            skip_q <= slow_in & ~skip_q;
            if (mem_req_in && !mem_ack_out && !skip_q) begin
                mem_ack_out <= 1'b1;
                if (break_ff_in && mem_addr_in == 24'hFFFFE7)
                    mem_data_out <= 8'hFF;
                else
                    mem_data_out <= mem_addr_in[7:0] + 8'h11;
            end else begin
                mem_ack_out <= 1'b0;
                // Released bus flips the last byte to its complement every cycle
                mem_data_out <= ~mem_data_out;
            end
        end
    end
endmodule

// ===== ivd_dispatch_checker.sv
`timescale 1ns/100ps
module ivd_dispatch_checker
    import ivd_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic i_flag_in,
    input wire logic [EXIT_W-1:0] exit_priority_in,
    input wire logic fast_bank_mode_in,
    input wire logic [ADDR_W-1:0] fast_vector_reg_in,
    input wire logic fast_return_instr_in,
    input wire logic mem_ack_in,
    input wire logic mem_req_out,
    input wire logic [ADDR_W-1:0] mem_addr_out,
    input wire logic branch_valid_out,
    input wire logic [ADDR_W-1:0] branch_addr_out,
    input wire logic [NUM_SRC-1:0] req_pending_out,
    input wire logic [NUM_SRC-1:0] ack_out,
    input wire logic [FLAG_W-1:0] saved_flag_reg_out,
    input wire logic [ADDR_W-1:0] saved_pc_reg_out,
    input wire logic restore_valid_out,
    input wire logic [FLAG_W-1:0] restore_flag_out,
    input wire logic [ADDR_W-1:0] restore_pc_out,
    input wire logic bank1_select_out,
    input wire logic in_fast_out,
    input wire logic busy_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);
    // ============================================================
    // Fast path steps
    sequence fast_entry_s;
        ##4 branch_valid_out && branch_addr_out == fast_vector_reg_in;
    endsequence
    sequence fast_ret_s;
        ##3 restore_valid_out && restore_pc_out == saved_pc_reg_out
            && restore_flag_out == saved_flag_reg_out;
    endsequence
    fast_entry_a: assert property ($rose(in_fast_out) |-> fast_entry_s)
        else $error("fast branch late or wrong");
    fast_ret_a: assert property (fast_return_instr_in && in_fast_out && !busy_out
        |-> fast_ret_s)
        else $error("fast return late or wrong");
    fast_only_a: assert property ($rose(in_fast_out) |-> $past(exit_priority_in[HS_BIT]))
        else $error("fast path without enable");
    bank_sel_a: assert property ($rose(in_fast_out)
        |-> bank1_select_out == $past(fast_bank_mode_in))
        else $error("bank select wrong");
    bank_drop_a: assert property (restore_valid_out
        |-> !in_fast_out && !bank1_select_out)
        else $error("fast state kept after return");
    mem_hold_a: assert property (mem_req_out && !mem_ack_in
        |=> mem_req_out && $stable(mem_addr_out))
        else $error("read request dropped");
    mem_step_a: assert property (mem_req_out && mem_ack_in ##1 mem_req_out
        |-> mem_addr_out == $past(mem_addr_out) + 24'h000001)
        else $error("byte address not ascending");
    ack_cond_a: assert property (|ack_out |-> $past(i_flag_in) && $onehot(ack_out))
        else $error("maskable accepted while masked");
    req_clear_a: assert property (|ack_out |-> (req_pending_out & ack_out) == '0)
        else $error("request bit kept after acknowledge");
endmodule
bind ivd_dispatch ivd_dispatch_checker u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .i_flag_in(i_flag_in), .exit_priority_in(exit_priority_in),
    .fast_bank_mode_in(fast_bank_mode_in),
    .fast_vector_reg_in(fast_vector_reg_in), .fast_return_instr_in(fast_return_instr_in),
    .mem_ack_in(mem_ack_in), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
    .branch_valid_out(branch_valid_out), .branch_addr_out(branch_addr_out),
    .req_pending_out(req_pending_out), .ack_out(ack_out),
    .saved_flag_reg_out(saved_flag_reg_out), .saved_pc_reg_out(saved_pc_reg_out),
    .restore_valid_out(restore_valid_out), .restore_flag_out(restore_flag_out),
    .restore_pc_out(restore_pc_out), .bank1_select_out(bank1_select_out),
    .in_fast_out(in_fast_out), .busy_out(busy_out));

// ===== interrupt_vector_dispatch_test.sv
`timescale 1ns/100ps
module interrupt_vector_dispatch_test;
    import ivd_pkg::*;
    typedef struct packed {
        logic [3:0] sp;
        logic [5:0] num;
        logic [2:0] lvl;
        logic ifl;
        logic redir;
        logic [23:0] ent;
    } ivd_row_s;
    logic clk_in = 0, reset_n_in = 0, i_flag_in = 0, bank_in = 1, fret_in = 0;
    logic slow = 0, break_ff = 0, mem_ack, mem_req, bv, rv, bank1, in_fast, busy;
    logic [NUM_SRC-1:0] set_in = '0, clr_in = '0, pend, ack;
    logic [NUM_SRC*PRI_W-1:0] lvl_in = '0;
    logic [EXIT_W-1:0] exit_in = 8'h00;
    logic [NUM_SP-1:0] sp_in = '0;
    logic [SWNUM_W-1:0] num_in = 6'h00;
    logic [7:0] mem_data;
    logic [23:0] mem_addr, ba, fa, spc, rpc, ba_seen;
    logic [15:0] sfl, rfl;
    logic hit;
    logic [21:0] ak;
    int err_count = 0, n_tests = 0, c;
    // Even base keeps vector fetches aligned
    localparam logic [23:0] BASE = 24'h00A000;
    localparam logic [23:0] PC = 24'h012345, FVEC = 24'h0F1230;
    localparam logic [15:0] FLAGS_VAL = 16'hA5C3;
    ivd_row_s rows[15] = '{
        '{4'hF, 6'h08, 3'h3, 1'b1, 1'b0, 24'h0}, '{4'hF, 6'h0C, 3'h5, 1'b1, 1'b0, 24'h0},
        '{4'hF, 6'h11, 3'h2, 1'b1, 1'b0, 24'h0}, '{4'hF, 6'h15, 3'h6, 1'b1, 1'b0, 24'h0},
        '{4'hF, 6'h0B, 3'h1, 1'b1, 1'b0, 24'h1}, '{4'hF, 6'h09, 3'h4, 1'b0, 1'b0, 24'h1},
        '{4'h1, 6'h00, 3'h0, 1'b0, 1'b0, VEC_EMU}, '{4'h2, 6'h00, 3'h0, 1'b0, 1'b0, VEC_EMU},
        '{4'h3, 6'h00, 3'h0, 1'b0, 1'b0, VEC_NMI}, '{4'h4, 6'h00, 3'h0, 1'b0, 1'b0, VEC_WDT},
        '{4'h5, 6'h00, 3'h0, 1'b0, 1'b0, VEC_AMATCH}, '{4'h6, 6'h00, 3'h0, 1'b0, 1'b0, VEC_UNDEF},
        '{4'h7, 6'h00, 3'h0, 1'b0, 1'b0, VEC_OVF}, '{4'h8, 6'h00, 3'h0, 1'b0, 1'b0, VEC_BREAK},
        '{4'h8, 6'h00, 3'h0, 1'b0, 1'b1, 24'h0}};
    ivd_dispatch u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .req_set_in(set_in),
        .req_clear_in(clr_in), .src_level_in(lvl_in), .i_flag_in(i_flag_in),
        .processor_priority_level_in(3'h1), .exit_priority_in(exit_in),
        .fast_bank_mode_in(bank_in), .flag_register_in(FLAGS_VAL), .pc_in(PC),
        .fast_vector_reg_in(FVEC), .vector_table_base_in(BASE), .sp_event_in(sp_in),
        .int_number_in(num_in), .fast_return_instr_in(fret_in), .mem_data_in(mem_data),
        .mem_ack_in(mem_ack), .mem_req_out(mem_req), .mem_addr_out(mem_addr),
        .branch_valid_out(bv), .branch_addr_out(ba), .req_pending_out(pend), .ack_out(ack),
        .saved_flag_reg_out(sfl), .saved_pc_reg_out(spc), .restore_valid_out(rv),
        .restore_flag_out(rfl), .restore_pc_out(rpc), .bank1_select_out(bank1),
        .in_fast_out(in_fast), .busy_out(busy));
    ivd_mem_model u_mem (.clk_in(clk_in), .reset_n_in(reset_n_in), .mem_req_in(mem_req),
        .mem_addr_in(mem_addr), .slow_in(slow), .break_ff_in(break_ff), .mem_data_out(mem_data),
        .mem_ack_out(mem_ack));
    always #50 clk_in = ~clk_in;
    // ============================================================
    // Helpers
    function automatic logic [23:0] tgt(input logic [23:0] a);
        tgt = {a[7:0] + 8'h13, a[7:0] + 8'h12, a[7:0] + 8'h11};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wait_br(input int lim);
        logic [23:0] b;
        hit = 0;
        ak = '0;
        fa = '0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge clk_in);
            ak |= ack;
            if (mem_req === 1'b1 && fa === 24'h0) fa = mem_addr;
            if (bv === 1'b1) hit = 1;
        end
        b = ba;
        ba_seen = b;
        repeat (2) @(negedge clk_in);
    endtask
    task automatic finish_test;
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        err_count++;
        finish_test;
    end
    // ============================================================
    // Main sequence
    initial begin
        repeat (2) @(negedge clk_in);
        check({bv, mem_req, busy, in_fast, bank1, rv}, 32'h0, "outputs during reset");
        reset_n_in = 1;
        wait_br(40);
        check(fa, VEC_RESET, "reset fetch address");
        check(ba_seen, tgt(VEC_RESET), "reset target");
        foreach (rows[i]) begin
            lvl_in = '0;
            lvl_in[rows[i].num*3 +: 3] = rows[i].lvl;
            i_flag_in = rows[i].ifl;
            break_ff = rows[i].redir;
            slow = i[0];
            if (rows[i].sp == 4'hF) set_in[rows[i].num] = 1'b1;
            else sp_in[rows[i].sp] = 1'b1;
            @(negedge clk_in);
            set_in = '0;
            sp_in = '0;
            wait_br(rows[i].ent == 24'h1 ? 20 : 60);
            check(hit, rows[i].ent != 24'h1, "branch taken");
            if (rows[i].ent == 24'h1) begin
                check(pend[rows[i].num], 1'b1, "request kept");
                clr_in[rows[i].num] = 1'b1;
                @(negedge clk_in);
                clr_in = '0;
                @(negedge clk_in);
                check(pend[rows[i].num], 1'b0, "request cleared");
            end else begin
                check(ba_seen, tgt(rows[i].ent == 24'h0 ? 24'(BASE + 4 * rows[i].num)
                    : rows[i].ent), "vector target");
                check(ak, rows[i].sp == 4'hF ? 22'h1 << rows[i].num : 22'h0, "ack");
            end
        end
        num_in = 6'h2C;
        sp_in[SP_INT] = 1'b1;
        @(negedge clk_in);
        sp_in = '0;
        wait_br(60);
        check(ba_seen, tgt(BASE + 24'd176), "soft number target");
        // Fast path: a single level-7 source, no DMA source active
        exit_in = 8'h08;
        i_flag_in = 1;
        lvl_in = '0;
        lvl_in[13*3 +: 3] = 3'h7;
        set_in[13] = 1'b1;
        @(negedge clk_in);
        set_in = '0;
        for (c = 0; c < 20 && in_fast !== 1'b1; c++) @(negedge clk_in);
        check(sfl, FLAGS_VAL, "saved flags");
        check(spc, PC, "saved pc");
        check(bank1, 1'b1, "bank one");
        check(busy, 1'b1, "busy in fast entry");
        for (c = 0; c < 20 && bv !== 1'b1; c++) @(negedge clk_in);
        check(c, FAST_ENTRY_CYC - 1, "fast entry cycles");
        check(ba, FVEC, "fast target");
        repeat (3) @(negedge clk_in);
        fret_in = 1;
        @(negedge clk_in);
        fret_in = 0;
        for (c = 1; c < 20 && rv !== 1'b1; c++) @(negedge clk_in);
        check(c, FAST_RET_CYC, "fast return cycles");
        check(rfl, FLAGS_VAL, "restored flags");
        check(rpc, PC, "restored pc");
        check({in_fast, bank1}, 2'b00, "fast state dropped");
        finish_test;
    end
endmodule
